// file: inc/rcf_pkg.sv
// package of constants and types for the receive control frame status block
`default_nettype none

package rcf_pkg;

  // apb register byte offsets
  localparam logic [7:0] RCF_CTRL_OFS = 8'h00;
  localparam logic [7:0] RCF_STATUS_OFS = 8'h04;
  localparam logic [7:0] RCF_INT_EN_OFS = 8'h08;
  localparam logic [7:0] RCF_INT_CLR_OFS = 8'h0C;
  localparam logic [7:0] RCF_LAST_TYPE_OFS = 8'h10;

  // control register field positions
  localparam int RCF_CTRL_FWD_BIT = 0;
  localparam int RCF_CTRL_MODE_BIT = 1;

  // type vector bit positions
  localparam int RCF_TYPE_STD_FC_BIT = 0;
  localparam int RCF_TYPE_PFC_BIT = 1;
  localparam int RCF_TYPE_OTHER_BIT = 2;
  localparam int RCF_TYPE_W = 3;

  // reset values
  localparam logic RCF_FWD_RST = 1'h0;
  localparam logic [RCF_TYPE_W-1:0] RCF_TYPE_RST = 3'h0;
  localparam logic [RCF_TYPE_W-1:0] RCF_STATUS_RST = 3'h0;
  localparam logic [RCF_TYPE_W-1:0] RCF_INT_EN_RST = 3'h0;
  localparam logic [31:0] RCF_RDATA_RST = 32'h0000_0000;

  // flow control mode of the mac
  typedef enum logic [1:0] {
    RCF_MODE_STD = 2'h1,
    RCF_MODE_PFC = 2'h2
  } rcf_fc_mode_e;

  // classification of the word leaving the receive mac
  typedef struct packed {
    logic eop;
    logic std_fc;
    logic pfc;
    logic other_ctrl;
  } rcf_rx_in_s;

  // status handed to the client
  typedef struct packed {
    logic eop;
    logic [RCF_TYPE_W-1:0] ctrl_type;
  } rcf_rx_out_s;

endpackage

`default_nettype wire

// file: rtl/rcf_rx_ctrl_frame_status.sv
// receive control frame type reporting with apb registers and interrupt
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module rcf_rx_ctrl_frame_status
  import rcf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rcf_rx_in_s rx_in,
  output rcf_rx_out_s rx_out,
  output logic irq
);

  // configuration and state registers
  logic fwd_ctrl_reg;
  rcf_fc_mode_e fc_mode_reg;
  logic [RCF_TYPE_W-1:0] status_reg;
  logic [RCF_TYPE_W-1:0] status_next;
  logic [RCF_TYPE_W-1:0] int_en_reg;
  logic [RCF_TYPE_W-1:0] int_en_next;
  logic [RCF_TYPE_W-1:0] last_type_reg;
  logic [RCF_TYPE_W-1:0] type_next;
  logic [RCF_TYPE_W-1:0] type_reg;
  logic eop_reg;
  logic irq_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pslverr_reg;
  logic pslverr_next;
  logic setup_phase;
  logic wr_done;
  logic [RCF_TYPE_W-1:0] clr_mask;

  assign setup_phase = psel && !penable;
  assign wr_done = psel && penable && pready_reg && pwrite;
  assign clr_mask = (wr_done && paddr == RCF_INT_CLR_OFS) ? pwdata[RCF_TYPE_W-1:0] : 3'h0;
  // enable mask as it stands after this cycle's write, so irq never lags it
  assign int_en_next = (wr_done && paddr == RCF_INT_EN_OFS) ? pwdata[RCF_TYPE_W-1:0]
    : int_en_reg;

  // classify the current word; flags only on eop, suppressed per mode
  always_comb begin
    type_next = RCF_TYPE_RST;
    if (rx_in.eop) begin
      type_next[RCF_TYPE_STD_FC_BIT] = rx_in.std_fc;
      type_next[RCF_TYPE_PFC_BIT] = rx_in.pfc;
      type_next[RCF_TYPE_OTHER_BIT] = rx_in.other_ctrl;
      if (!fwd_ctrl_reg && fc_mode_reg == RCF_MODE_STD) begin
        type_next[RCF_TYPE_STD_FC_BIT] = 1'h0;
      end
      if (!fwd_ctrl_reg && fc_mode_reg == RCF_MODE_PFC) begin
        type_next[RCF_TYPE_PFC_BIT] = 1'h0;
      end
    end
  end

  // client-facing outputs, one cycle behind the mac word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      type_reg <= RCF_TYPE_RST;
      eop_reg <= 1'h0;
    end else begin
      type_reg <= type_next;
      eop_reg <= rx_in.eop;
    end
  end

  // last reported nonzero vector, for software inspection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_type_reg <= RCF_TYPE_RST;
    end else if (type_next != RCF_TYPE_RST) begin
      last_type_reg <= type_next;
    end
  end

  // sticky events; a new event beats a simultaneous clear
  always_comb begin
    status_next = (status_reg & ~clr_mask) | type_next;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= RCF_STATUS_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  // level interrupt from enabled sticky bits, tracking status and enable together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'h0;
    end else begin
      irq_reg <= |(status_next & int_en_next);
    end
  end

  // software-written configuration, applied at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_ctrl_reg <= RCF_FWD_RST;
      fc_mode_reg <= RCF_MODE_STD;
      int_en_reg <= RCF_INT_EN_RST;
    end else if (wr_done) begin
      case (paddr)
        RCF_CTRL_OFS: begin
          fwd_ctrl_reg <= pwdata[RCF_CTRL_FWD_BIT];
          fc_mode_reg <= pwdata[RCF_CTRL_MODE_BIT] ? RCF_MODE_PFC : RCF_MODE_STD;
        end
        RCF_INT_EN_OFS: begin
          int_en_reg <= pwdata[RCF_TYPE_W-1:0];
        end
        default: begin
          int_en_reg <= int_en_reg;
        end
      endcase
    end
  end

  // read mux and unmapped-address decode, prepared in the setup cycle
  always_comb begin
    prdata_next = RCF_RDATA_RST;
    pslverr_next = 1'h0;
    case (paddr)
      RCF_CTRL_OFS: begin
        prdata_next[RCF_CTRL_FWD_BIT] = fwd_ctrl_reg;
        prdata_next[RCF_CTRL_MODE_BIT] = (fc_mode_reg == RCF_MODE_PFC);
      end
      RCF_STATUS_OFS: begin
        prdata_next[RCF_TYPE_W-1:0] = status_reg;
      end
      RCF_INT_EN_OFS: begin
        prdata_next[RCF_TYPE_W-1:0] = int_en_reg;
      end
      RCF_INT_CLR_OFS: begin
        prdata_next = RCF_RDATA_RST;
      end
      RCF_LAST_TYPE_OFS: begin
        prdata_next[RCF_TYPE_W-1:0] = last_type_reg;
      end
      default: begin
        pslverr_next = 1'h1;
      end
    endcase
  end

  // apb answer: ready in the first access cycle, dropped after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= RCF_RDATA_RST;
      pready_reg <= 1'h0;
      pslverr_reg <= 1'h0;
    end else if (setup_phase) begin
      prdata_reg <= pwrite ? RCF_RDATA_RST : prdata_next;
      pready_reg <= 1'h1;
      pslverr_reg <= pslverr_next;
    end else begin
      prdata_reg <= RCF_RDATA_RST;
      pready_reg <= 1'h0;
      pslverr_reg <= 1'h0;
    end
  end

  // outputs straight from flip-flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign rx_out = '{eop: eop_reg, ctrl_type: type_reg};
  assign irq = irq_reg;

  // reported vector against the word it came from
  chk_quiet_no_eop: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_in.eop |=> rx_out.ctrl_type == 3'h0)
    else $error("type vector nonzero outside eop");

  chk_type_needs_eop: assert property (@(posedge pclk) disable iff (!presetn)
    rx_out.ctrl_type != 3'h0 |-> rx_out.eop)
    else $error("type flag shown without eop");

  chk_eop_aligned: assert property (@(posedge pclk) disable iff (!presetn)
    rx_out.eop == $past(rx_in.eop))
    else $error("eop and type vector misaligned");

  chk_data_frame_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rx_in.eop && !rx_in.std_fc && !rx_in.pfc && !rx_in.other_ctrl
    |=> rx_out.ctrl_type == 3'h0)
    else $error("data frame reported as control frame");

  // type flags: flow control passed or held at zero by mode and forwarding, other control always passed
  chk_std_fc_flag: assert property (@(posedge pclk) disable iff (!presetn)
    rx_in.eop && rx_in.std_fc && (fwd_ctrl_reg || fc_mode_reg != RCF_MODE_STD)
    |=> rx_out.ctrl_type[RCF_TYPE_STD_FC_BIT])
    else $error("standard flow control frame not flagged");

  chk_std_only_std: assert property (@(posedge pclk) disable iff (!presetn)
    rx_in.eop && !rx_in.std_fc |=> !rx_out.ctrl_type[RCF_TYPE_STD_FC_BIT])
    else $error("standard flow control flag without such a frame");

  chk_std_suppress: assert property (@(posedge pclk) disable iff (!presetn)
    !fwd_ctrl_reg && fc_mode_reg == RCF_MODE_STD
    |=> !rx_out.ctrl_type[RCF_TYPE_STD_FC_BIT])
    else $error("standard flow control flag not suppressed");

  chk_pfc_flag: assert property (@(posedge pclk) disable iff (!presetn)
    rx_in.eop && rx_in.pfc && (fwd_ctrl_reg || fc_mode_reg != RCF_MODE_PFC)
    |=> rx_out.ctrl_type[RCF_TYPE_PFC_BIT])
    else $error("priority flow control frame not flagged");

  chk_pfc_only_pfc: assert property (@(posedge pclk) disable iff (!presetn)
    rx_in.eop && !rx_in.pfc |=> !rx_out.ctrl_type[RCF_TYPE_PFC_BIT])
    else $error("priority flow control flag without such a frame");

  chk_pfc_suppress: assert property (@(posedge pclk) disable iff (!presetn)
    !fwd_ctrl_reg && fc_mode_reg == RCF_MODE_PFC
    |=> !rx_out.ctrl_type[RCF_TYPE_PFC_BIT])
    else $error("priority flow control flag not suppressed");

  chk_other_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
    rx_in.eop |=> rx_out.ctrl_type[RCF_TYPE_OTHER_BIT] == $past(rx_in.other_ctrl))
    else $error("other control frame flag wrong");

  // sticky status, last vector and interrupt level
  chk_status_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_out.ctrl_type & ~status_reg) == 3'h0)
    else $error("reported event missing from status");

  chk_status_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_done |=> ($past(status_reg) & ~status_reg) == 3'h0)
    else $error("status bit dropped without a clear");

  chk_clear_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_mask & ~type_next) != 3'h0
    |=> (status_reg & $past(clr_mask) & ~$past(type_next)) == 3'h0)
    else $error("status bit survived its clear");

  chk_last_type_kept: assert property (@(posedge pclk) disable iff (!presetn)
    type_next != RCF_TYPE_RST |=> last_type_reg == $past(type_next))
    else $error("last vector not captured");

  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == (|(status_reg & int_en_reg)))
    else $error("interrupt level differs from enabled status");

  chk_sticky_irq: assert property (@(posedge pclk) disable iff (!presetn)
    (|(type_next & int_en_reg)) && !wr_done |=> irq ##1 (irq || $past(wr_done)))
    else $error("enabled event did not raise interrupt");

  // apb answer timing and qualifiers
  chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase |=> pready ##1 !pready)
    else $error("apb ready not one cycle after setup");

  chk_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> $past(setup_phase))
    else $error("apb ready without a setup cycle");

  chk_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("apb error outside the answer cycle");

  chk_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == RCF_RDATA_RST)
    else $error("read data nonzero outside the answer cycle");

  chk_clear_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && paddr == RCF_INT_CLR_OFS |-> prdata == RCF_RDATA_RST)
    else $error("clear register read nonzero");

  // main scenarios
  cov_std_fc: cover property (@(posedge pclk) disable iff (!presetn)
    rx_out.ctrl_type[RCF_TYPE_STD_FC_BIT]);
  cov_pfc_suppressed: cover property (@(posedge pclk) disable iff (!presetn)
    rx_in.eop && rx_in.pfc && !fwd_ctrl_reg && fc_mode_reg == RCF_MODE_PFC);
  cov_std_suppressed: cover property (@(posedge pclk) disable iff (!presetn)
    rx_in.eop && rx_in.std_fc && !fwd_ctrl_reg && fc_mode_reg == RCF_MODE_STD);
  cov_other_irq: cover property (@(posedge pclk) disable iff (!presetn)
    rx_out.ctrl_type[RCF_TYPE_OTHER_BIT] ##1 irq);
  cov_clear_meets_event: cover property (@(posedge pclk) disable iff (!presetn)
    |(type_next & clr_mask));

endmodule // rcf_rx_ctrl_frame_status

`default_nettype wire

// file: verification/rcf_client_model.sv
// client side model that pairs the type vector with its end-of-packet word
`timescale 1ns/1ps
`default_nettype none

module rcf_client_model
  import rcf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire rcf_rx_out_s rx_out,
  output logic [RCF_TYPE_W-1:0] last_type
);
  // keep the vector of the last control frame, taken on eop words only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_type <= RCF_TYPE_RST;
    end else if (rx_out.eop && rx_out.ctrl_type != '0) begin
      last_type <= rx_out.ctrl_type;
    end
  end
endmodule // rcf_client_model

`default_nettype wire

// file: verification/tb.sv
// self-checking testbench for the receive control frame status block
`timescale 1ns/1ps
`default_nettype none

module tb
  import rcf_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] e;
  logic [2:0] last_type;
  rcf_rx_in_s rx_in, w;
  rcf_rx_out_s rx_out;
  int n_mismatch, n_tests;

  rcf_rx_ctrl_frame_status rcf_rx_ctrl_frame_status_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in(rx_in), .rx_out(rx_out),
    .irq(irq));
  rcf_client_model rcf_client_model_i (.pclk(pclk), .presetn(presetn), .rx_out(rx_out),
    .last_type(last_type));

  // counts and verdict
  task automatic close_out();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // compare seen against expected
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // one receive word, then idle; outputs settled on return
  task automatic send(input rcf_rx_in_s x);
    @(posedge pclk);
    rx_in <= x;
    @(posedge pclk);
    rx_in <= '0;
    #1;
  endtask

  // free running clock
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end

  // main sequence
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rx_in = '0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, RCF_CTRL_OFS, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    chk("ctrl err", {31'h0, err}, 32'h0);
    apb(1'h0, RCF_INT_CLR_OFS, 32'h0);
    chk("clr reads zero", rd, 32'h0);
    apb(1'h0, RCF_STATUS_OFS, 32'h0);
    chk("status reset", rd, 32'h0);
    apb(1'h0, 8'h20, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    // every mode and forwarding setting against every frame kind
    for (int c = 0; c < 4; c++) begin
      apb(1'h1, RCF_CTRL_OFS, 32'(c));
      apb(1'h0, RCF_CTRL_OFS, 32'h0);
      chk("ctrl", rd, 32'(c));
      for (int k = 0; k < 5; k++) begin
        w = {k < 4, k == 0 || k == 4, k == 1 || k == 4, k == 2 || k == 4};
        e = {k < 4, k == 2, k == 1 && c != 2, k == 0 && c != 0};
        send(w);
        chk("rx_out", {28'h0, rx_out}, {28'h0, e});
      end
    end
    chk("client type", {29'h0, last_type}, 32'h4);
    apb(1'h0, RCF_LAST_TYPE_OFS, 32'h0);
    chk("last type", rd, 32'h4);
    // interrupt raised, masked and cleared
    apb(1'h1, RCF_INT_CLR_OFS, 32'h7);
    apb(1'h1, RCF_INT_EN_OFS, 32'h2);
    send(4'h9);
    chk("irq masked", {31'h0, irq}, 32'h0);
    send(4'hA);
    chk("irq set", {31'h0, irq}, 32'h1);
    apb(1'h0, RCF_STATUS_OFS, 32'h0);
    chk("status", rd, 32'h6);
    apb(1'h1, RCF_INT_CLR_OFS, 32'h2);
    @(posedge pclk);
    #1;
    chk("irq clear", {31'h0, irq}, 32'h0);
    apb(1'h0, RCF_STATUS_OFS, 32'h0);
    chk("status clr", rd, 32'h4);
    // enabling a pending bit raises the interrupt at the write edge
    apb(1'h1, RCF_INT_EN_OFS, 32'h4);
    #1;
    chk("irq enable", {31'h0, irq}, 32'h1);
    close_out();
  end
endmodule // tb

`default_nettype wire
